// [verilog/tba_defines.svh]
`ifndef TBA_DEFINES_SVH
`define TBA_DEFINES_SVH
// clock period in ns, kept for reference by timing-aware users
`define TBA_CLK_PERIOD_NS 5
// bus-driven output level when negated (active low pin)
`define TBA_DRIVEN_N_IDLE 1'b1
`define TBA_XFER_CNT_W    4
`endif

// [verilog/tba_pkg.sv]
package tba_pkg;
  typedef enum logic [1:0] {
    TBA_RESET,
    TBA_EXT_OWNED,
    TBA_IMPLICIT,
    TBA_EXPLICIT
  } tba_state_t;
endpackage

// [verilog/tba_own_drive.sv]
`timescale 1ns/1ps
`include "tba_defines.svh"
// output-enable stage: drives the shared bus only while explicitly owning it
module tba_own_drive (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic drive_next,
  output logic      bus_drive_oe_reg,
  output logic      bus_driven_out_n_reg
);
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      bus_drive_oe_reg     <= 1'b0;
      bus_driven_out_n_reg <= `TBA_DRIVEN_N_IDLE;
    end else begin
      bus_drive_oe_reg     <= drive_next;
      bus_driven_out_n_reg <= ~drive_next;
    end
  end
endmodule

// [verilog/tba_arbiter.sv]
`timescale 1ns/1ps
// Overview of operation
// - state changes only on rising sys_clk edge, fully synchronous
// - grant input is active low from partner hold request; bus driven feeds its ack
// - request while granted: assert bus driven and transfer start together
// - a transfer may begin the cycle after grant becomes asserted
// - lock clear, grant gone: finish cycle, then release bus and outputs
// - burst-inhibited series keeps bus driven until its last transfer ends or an error termination ends it
// - lock set in explicit ownership: grant loss does not release bus
// - lock cleared with grant negated: release bus the following clock if idle, else once the cycle ends
// - lock set while implicit owner: take explicit ownership next clock
// - reset input or watchdog reset forces reset state from anywhere
// - leaving reset: implicit if granted, else external master owned
// - external master owned: bus undriven, memory controls may still assert
// - implicit or external owned: grant plus lock or request gives explicit, grant alone implicit, no grant external owned
// - explicit only when granted with cycle started, or lock set
// - explicit with grant held: keep ownership whatever cycles run
// - explicit, no grant, no lock: leave at end of cycle or if idle
// - end of cycle is normal or error termination; series counts as one
// - bus driven and bus drive only in explicit ownership
`include "tba_defines.svh"
module tba_arbiter (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic reset_in_n,
  input  wire logic wdog_reset,
  input  wire logic bus_grant_in_n,
  input  wire logic bus_lock_bit,
  input  wire logic int_bus_req,
  input  wire logic burst_inhibit,
  input  wire logic last_transfer,
  input  wire logic transfer_ack_n,
  input  wire logic transfer_error_ack_n,
  output logic      bus_driven_out_n,
  output logic      bus_drive_oe,
  output logic      transfer_start_n,
  output logic      xfer_active,
  output logic      mem_ctrl_allowed,
  output logic [1:0] arb_state
);
  tba_pkg::tba_state_t state_reg;
  tba_pkg::tba_state_t state_next;
  logic                granted;
  logic                rst_any;
  logic                term;
  logic                end_of_cycle;
  logic                start_now;
  logic                xfer_reg;
  logic                drive_next;

  assign granted = ~bus_grant_in_n;
  assign rst_any = ~reset_in_n | wdog_reset;
  assign term    = xfer_reg & (~transfer_ack_n | ~transfer_error_ack_n);
  // error aborts the whole series; normal ack only ends it on the last transfer
  assign end_of_cycle = term & (~transfer_error_ack_n | ~burst_inhibit | last_transfer);
  // start when explicit owner (or entering it from a request) with grant held
  assign start_now = ~rst_any & int_bus_req & ~xfer_reg & granted &
                     (state_reg == tba_pkg::TBA_EXPLICIT ||
                      state_reg == tba_pkg::TBA_IMPLICIT ||
                      state_reg == tba_pkg::TBA_EXT_OWNED);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tba_pkg::TBA_RESET: begin
        state_next = granted ? tba_pkg::TBA_IMPLICIT : tba_pkg::TBA_EXT_OWNED;
      end
      tba_pkg::TBA_EXT_OWNED, tba_pkg::TBA_IMPLICIT: begin
        if (!granted) begin
          state_next = tba_pkg::TBA_EXT_OWNED;
        end else if (bus_lock_bit || int_bus_req) begin
          state_next = tba_pkg::TBA_EXPLICIT;
        end else begin
          state_next = tba_pkg::TBA_IMPLICIT;
        end
      end
      tba_pkg::TBA_EXPLICIT: begin
        if (granted || bus_lock_bit) begin
          state_next = tba_pkg::TBA_EXPLICIT;
        end else if (!xfer_reg || end_of_cycle) begin
          state_next = tba_pkg::TBA_EXT_OWNED;
        end else begin
          state_next = tba_pkg::TBA_EXPLICIT;
        end
      end
      default: state_next = tba_pkg::TBA_RESET;
    endcase
    if (rst_any) begin
      state_next = tba_pkg::TBA_RESET;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_reg <= tba_pkg::TBA_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // a transfer is in flight from its start until its end of cycle
  always_ff @(posedge sys_clk) begin
    if (!reset_n || rst_any) begin
      xfer_reg <= 1'b0;
    end else if (start_now) begin
      xfer_reg <= 1'b1;
    end else if (end_of_cycle) begin
      xfer_reg <= 1'b0;
    end
  end

  // transfer start pulses only in a cycle where bus driven is asserted
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      transfer_start_n <= 1'b1;
    end else begin
      transfer_start_n <= ~start_now;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      xfer_active      <= 1'b0;
      mem_ctrl_allowed <= 1'b0;
      arb_state        <= 2'h0;
    end else begin
      xfer_active      <= start_now | (xfer_reg & ~end_of_cycle);
      mem_ctrl_allowed <= (state_next == tba_pkg::TBA_EXT_OWNED);
      arb_state        <= state_next;
    end
  end

  assign drive_next = (state_next == tba_pkg::TBA_EXPLICIT);

  tba_own_drive u_drive (
    .sys_clk              (sys_clk),
    .reset_n              (reset_n),
    .drive_next           (drive_next),
    .bus_drive_oe_reg     (bus_drive_oe),
    .bus_driven_out_n_reg (bus_driven_out_n)
  );

  property p_driven_only_explicit;
    @(posedge sys_clk) disable iff (!reset_n)
    !bus_driven_out_n |-> (state_reg == tba_pkg::TBA_EXPLICIT);
  endproperty
  a_driven_only_explicit: assert property (p_driven_only_explicit)
    else $error("bus driven outside explicit ownership");

  property p_start_with_driven;
    @(posedge sys_clk) disable iff (!reset_n)
    !transfer_start_n |-> !bus_driven_out_n && bus_drive_oe;
  endproperty
  a_start_with_driven: assert property (p_start_with_driven)
    else $error("transfer start without bus driven");

  property p_reset_enter;
    @(posedge sys_clk) disable iff (!reset_n)
    rst_any |=> state_reg == tba_pkg::TBA_RESET;
  endproperty
  a_reset_enter: assert property (p_reset_enter)
    else $error("reset source did not force reset state");

  property p_reset_leave;
    @(posedge sys_clk) disable iff (!reset_n)
    (state_reg == tba_pkg::TBA_RESET && !rst_any) |=>
      state_reg == ($past(granted) ? tba_pkg::TBA_IMPLICIT : tba_pkg::TBA_EXT_OWNED);
  endproperty
  a_reset_leave: assert property (p_reset_leave)
    else $error("wrong state after reset");

  property p_lock_holds;
    @(posedge sys_clk) disable iff (!reset_n)
    (state_reg == tba_pkg::TBA_EXPLICIT && bus_lock_bit && !rst_any) |=>
      state_reg == tba_pkg::TBA_EXPLICIT && !bus_driven_out_n;
  endproperty
  a_lock_holds: assert property (p_lock_holds)
    else $error("lock did not hold the bus");

  property p_release;
    @(posedge sys_clk) disable iff (!reset_n)
    (state_reg == tba_pkg::TBA_EXPLICIT && !granted && !bus_lock_bit && !xfer_reg
     && !rst_any) |=> bus_driven_out_n && !bus_drive_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("bus not released");

  property p_implicit_lock;
    @(posedge sys_clk) disable iff (!reset_n)
    (state_reg == tba_pkg::TBA_IMPLICIT && granted && bus_lock_bit && !rst_any) |=>
      state_reg == tba_pkg::TBA_EXPLICIT;
  endproperty
  a_implicit_lock: assert property (p_implicit_lock)
    else $error("lock did not give explicit ownership");

  property p_hold_mid;
    @(posedge sys_clk) disable iff (!reset_n)
    (state_reg == tba_pkg::TBA_EXPLICIT && xfer_reg && !end_of_cycle && !rst_any) |=>
      state_reg == tba_pkg::TBA_EXPLICIT;
  endproperty
  a_hold_mid: assert property (p_hold_mid)
    else $error("bus left in the middle of a cycle");

  property p_grant_keeps;
    @(posedge sys_clk) disable iff (!reset_n)
    (state_reg == tba_pkg::TBA_EXPLICIT && granted && !rst_any) |=>
      state_reg == tba_pkg::TBA_EXPLICIT;
  endproperty
  a_grant_keeps: assert property (p_grant_keeps)
    else $error("explicit ownership lost while granted");

  property p_oe_matches;
    @(posedge sys_clk) disable iff (!reset_n)
    bus_drive_oe == !bus_driven_out_n;
  endproperty
  a_oe_matches: assert property (p_oe_matches)
    else $error("drive enable disagrees with bus driven");

  property p_start_one_cycle;
    @(posedge sys_clk) disable iff (!reset_n)
    !transfer_start_n |=> transfer_start_n;
  endproperty
  a_start_one_cycle: assert property (p_start_one_cycle)
    else $error("transfer start longer than one cycle");

  property p_start_needs_grant;
    @(posedge sys_clk) disable iff (!reset_n)
    !transfer_start_n |-> $past(granted);
  endproperty
  a_start_needs_grant: assert property (p_start_needs_grant)
    else $error("transfer start without grant in the cycle before");

  property p_mem_only_ext;
    @(posedge sys_clk) disable iff (!reset_n)
    mem_ctrl_allowed == (state_reg == tba_pkg::TBA_EXT_OWNED);
  endproperty
  a_mem_only_ext: assert property (p_mem_only_ext)
    else $error("memory controls allowed outside external ownership");

  property p_ext_stays;
    @(posedge sys_clk) disable iff (!reset_n)
    (state_reg == tba_pkg::TBA_EXT_OWNED && !granted && !rst_any) |=>
      state_reg == tba_pkg::TBA_EXT_OWNED;
  endproperty
  a_ext_stays: assert property (p_ext_stays)
    else $error("left external ownership without grant");

  property p_implicit_idle;
    @(posedge sys_clk) disable iff (!reset_n)
    (state_reg != tba_pkg::TBA_EXPLICIT && state_reg != tba_pkg::TBA_RESET && granted
     && !bus_lock_bit && !int_bus_req && !rst_any) |=>
      state_reg == tba_pkg::TBA_IMPLICIT && bus_driven_out_n;
  endproperty
  a_implicit_idle: assert property (p_implicit_idle)
    else $error("idle grant did not give implicit ownership");

  property p_req_start;
    @(posedge sys_clk) disable iff (!reset_n)
    (state_reg != tba_pkg::TBA_EXPLICIT && state_reg != tba_pkg::TBA_RESET && granted
     && int_bus_req && !rst_any) |=>
      state_reg == tba_pkg::TBA_EXPLICIT && !transfer_start_n && !bus_driven_out_n;
  endproperty
  a_req_start: assert property (p_req_start)
    else $error("granted request did not start at once");

  property p_enter_explicit;
    @(posedge sys_clk) disable iff (!reset_n)
    (state_reg != tba_pkg::TBA_EXPLICIT) ##1 (state_reg == tba_pkg::TBA_EXPLICIT) |->
      $past(granted) && ($past(bus_lock_bit) || !transfer_start_n);
  endproperty
  a_enter_explicit: assert property (p_enter_explicit)
    else $error("explicit ownership without grant and cause");

  property p_explicit_release;
    @(posedge sys_clk) disable iff (!reset_n)
    (state_reg == tba_pkg::TBA_EXPLICIT && !granted && !bus_lock_bit && end_of_cycle
     && !rst_any) |=>
      state_reg == tba_pkg::TBA_EXT_OWNED && bus_driven_out_n && !bus_drive_oe;
  endproperty
  a_explicit_release: assert property (p_explicit_release)
    else $error("bus kept after end of cycle without grant");

  property p_error_ends;
    @(posedge sys_clk) disable iff (!reset_n)
    (xfer_reg && !transfer_error_ack_n && !rst_any) |=>
      !xfer_active;
  endproperty
  a_error_ends: assert property (p_error_ends)
    else $error("error did not end the transfer");

  property p_rst_undriven;
    @(posedge sys_clk) disable iff (!reset_n)
    rst_any |=>
      bus_driven_out_n && !bus_drive_oe && transfer_start_n && !mem_ctrl_allowed;
  endproperty
  a_rst_undriven: assert property (p_rst_undriven)
    else $error("bus driven during reset state");

  property p_series_holds;
    @(posedge sys_clk) disable iff (!reset_n)
    (state_reg == tba_pkg::TBA_EXPLICIT && xfer_reg && burst_inhibit && !last_transfer
     && transfer_error_ack_n && !rst_any) |=>
      !bus_driven_out_n;
  endproperty
  a_series_holds: assert property (p_series_holds)
    else $error("bus released inside a burst-inhibited series");
endmodule

// [verif/tba_ext_master.sv]
`timescale 1ns/1ps
// the one other master: its hold request is the device grant (active low)
module tba_ext_master (
  input  wire logic sys_clk,
  input  wire logic want_bus,
  input  wire logic hold_acknowledge_in,
  output logic      hold_request_out,
  output logic      ext_driving
);
  initial begin
    hold_request_out = 1'b0;
    ext_driving = 1'b0;
  end
  // hold acknowledge is the bus-driven pin wired straight in: high once the device let go
  // on giving up, the request stays high one more cycle so its own drivers are off
  // before the grant is seen
  always @(negedge sys_clk) begin
    ext_driving <= want_bus & hold_request_out & hold_acknowledge_in;
    hold_request_out <= want_bus | ext_driving;
  end
endmodule

// [verif/two_wire_bus_arbitration_tb.sv]
`timescale 1ns/1ps
module two_wire_bus_arbitration_tb;
  // {drv_n, oe, start_n, busy, mem_ctrl, state}
  localparam logic [6:0] RST = 7'h50, EMO = 7'h55, IMP = 7'h52, EXI = 7'h33, EXT = 7'h2B;
  localparam logic [6:0] EXB = 7'h3B;
  logic       sys_clk = 1'b0, reset_n = 1'b0, rin_n = 1'b1, wdog = 1'b0, lock = 1'b0;
  logic       req = 1'b0, bi = 1'b0, last = 1'b0, ack_n = 1'b1, err_n = 1'b1, want = 1'b0;
  logic       drv_n, oe, start_n, busy, mem, gnt_n, ext_drv;
  logic [1:0] st;
  int         errors = 0;
  int         n_compared = 0;
  always #2.5 sys_clk = ~sys_clk;
  tba_arbiter DUT (.sys_clk(sys_clk), .reset_n(reset_n), .reset_in_n(rin_n),
    .wdog_reset(wdog), .bus_grant_in_n(gnt_n), .bus_lock_bit(lock), .int_bus_req(req),
    .burst_inhibit(bi), .last_transfer(last), .transfer_ack_n(ack_n),
    .transfer_error_ack_n(err_n), .bus_driven_out_n(drv_n), .bus_drive_oe(oe),
    .transfer_start_n(start_n), .xfer_active(busy), .mem_ctrl_allowed(mem), .arb_state(st));
  tba_ext_master u_ext (.sys_clk(sys_clk), .want_bus(want), .hold_acknowledge_in(drv_n),
    .hold_request_out(gnt_n), .ext_driving(ext_drv));
  task automatic chk(input logic [6:0] exp);
    n_compared++;
    if ({drv_n, oe, start_n, busy, mem, st} !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, {drv_n, oe, start_n, busy, mem, st}, exp);
    end
  endtask
  // the other master must never drive while the device still shows bus driven
  task automatic chk_free();
    n_compared++;
    if ((ext_drv & ~drv_n) !== 1'b0) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, ext_drv & ~drv_n, 1'b0);
    end
  endtask
  always @(negedge sys_clk) begin
    if (reset_n) begin
      chk_free();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // g high asks the other master to hand the bus over
  task automatic grant(input logic g);
    // lands after the model has sampled this edge, so it always reacts one edge later
    want <= ~g;
    for (int i = 0; i < 8 && gnt_n !== ~g; i++) cyc(1);
    cyc(1);
  endtask
  task automatic t_lock();
    lock = 1'b1;
    cyc(1);
    chk(EXI);
    grant(1'b0);
    cyc(2);
    chk(EXI);
    lock = 1'b0;
    cyc(1);
    chk(EMO);
    req = 1'b1;
    cyc(2);
    chk(EMO);
    req = 1'b0;
  endtask
  task automatic t_xfer();
    grant(1'b1);
    chk(IMP);
    req = 1'b1;
    cyc(1);
    chk(EXT);
    req = 1'b0;
    ack_n = 1'b0;
    cyc(1);
    ack_n = 1'b1;
    chk(EXI);
    bi = 1'b1;
    req = 1'b1;
    cyc(1);
    chk(EXT);
    req = 1'b0;
    grant(1'b0);
    ack_n = 1'b0;
    cyc(1);
    ack_n = 1'b1;
    chk(EXB);
    last = 1'b1;
    ack_n = 1'b0;
    cyc(1);
    ack_n = 1'b1;
    last = 1'b0;
    chk(EMO);
  endtask
  task automatic t_err();
    grant(1'b1);
    req = 1'b1;
    cyc(1);
    req = 1'b0;
    grant(1'b0);
    err_n = 1'b0;
    cyc(1);
    err_n = 1'b1;
    bi = 1'b0;
    chk(EMO);
  endtask
  task automatic t_rst();
    wdog = 1'b1;
    cyc(1);
    chk(RST);
    wdog = 1'b0;
    cyc(1);
    chk(EMO);
    grant(1'b1);
    lock = 1'b1;
    cyc(1);
    rin_n = 1'b0;
    cyc(1);
    chk(RST);
    rin_n = 1'b1;
    lock = 1'b0;
    cyc(1);
    chk(IMP);
  endtask
  task automatic results();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    results();
  end
  initial begin
    cyc(16);
    reset_n = 1'b1;
    cyc(1);
    chk(IMP);
    t_lock();
    t_xfer();
    t_err();
    t_rst();
    results();
  end
endmodule
